// ---- src/usbl_ctrl.sv ----
// usbl_ctrl: register file, event flags and endpoint answers of the usb link
// assumes the serial engine inputs are synchronous to clk_sys and one-cycle
// pulses except bus_idle, se0, kstate and bus_reset which are levels
// Function
// - latch token pid bits 3:2 read-only
// - mirror se0 and k line states
// - flags set by hardware, cleared writing zero
// - sleep request after idle over 3 ms
// - flag late dma service
// - transfer done only for clean acked transfers
// - error flag on timeout crc stuff frame
// - event lost when err or sof repeats
// - wake flag on activity while asleep
// - bus reset clears address and endpoints
// - sof flag on keep-alive and resume end
// - irq when non-wake flag and mask, not disabled
// - drive resume while resume bit set
// - power-down bit turns regulator off
// - force sleep bit, cleared by activity
// - force reset holds reset, irq on release
// - seven-bit address, top bit reads zero
// - expect-status stalls nonzero out data
// - send toggle set on setup, flips on ack
// - send state selects off stall nak send
// - done in or setup sets state nak
// - token kind and endpoint frozen while done
// - all valid endpoints nak while done set
`timescale 1ns/1ps
module usbl_ctrl #(
    parameter int IDLE_CYCLES = usbl_pkg::IDLE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // processor
    input wire logic cpu_irq_disable,
    output logic irq,
    output logic wake_irq,
    // serial engine
    input usbl_pkg::usbl_sie_t sie,
    output usbl_pkg::usbl_ans_t ans,
    // link control
    output logic iface_reset,
    output logic resume_drive,
    output logic regulator_off,
    output logic suspended
);

    logic [7:0] irq_status_r;
    logic [7:0] irq_mask_r;
    logic [3:0] usb_control_r;
    logic [6:0] function_address_r;
    logic [7:0] endpoint_tx_control_r [usbl_pkg::NUM_EP];
    logic [1:0] token_kind_r;
    logic [1:0] done_ep_r;
    logic line_se0_r;
    logic line_k_r;
    logic force_bus_reset_q_r;
    logic chk_en_r;
    logic [19:0] idle_cnt_r;
    logic [7:0] reg_rdata_r;
    logic [7:0] rd_nxt;
    logic [7:0] flag_set;
    logic usb_rst;
    logic idle_hit;
    logic err_any;
    logic sof_any;
    logic done_set;
    logic ep_ok;
    logic [7:0] ep_cur;
    logic wr_status;
    logic wr_ctrl;

    localparam logic [19:0] IDLE_LIM = 20'(IDLE_CYCLES);

    // rest of the interface follows a bus or forced reset
    assign usb_rst = sie.bus_reset | usb_control_r[usbl_pkg::CT_FORCE_BUS_RESET];
    assign wr_status = reg_wr && reg_addr == usbl_pkg::ADR_STATUS;
    assign wr_ctrl = reg_wr && reg_addr == usbl_pkg::ADR_CTRL;
    assign err_any = sie.err_timeout | sie.err_crc | sie.err_stuff |
        sie.err_frame;
    assign sof_any = sie.keepalive | sie.resume_end;
    // only clean transfers that were not refused
    assign done_set = sie.xfer_end & sie.pid_ok & sie.crc_ok & sie.toggle_ok &
        ~sie.overrun & ~sie.err_stuff & ~sie.err_frame & ~sie.hs_refused;
    // strictly more than the idle time
    assign idle_hit = chk_en_r & sie.bus_idle & (idle_cnt_r == IDLE_LIM);
    assign ep_ok = 32'(sie.token_ep) < usbl_pkg::NUM_EP;
    assign ep_cur = ep_ok ? endpoint_tx_control_r[sie.token_ep] : 8'h00;

    always_comb begin
        flag_set = 8'h00;
        flag_set[usbl_pkg::ST_IDLE] = idle_hit;
        flag_set[usbl_pkg::ST_DMA] = sie.dma_late;
        flag_set[usbl_pkg::ST_DONE] = done_set;
        flag_set[usbl_pkg::ST_ERR] = err_any;
        flag_set[usbl_pkg::ST_LOST] =
            (err_any & irq_status_r[usbl_pkg::ST_ERR]) |
            (sof_any & irq_status_r[usbl_pkg::ST_SOF]);
        flag_set[usbl_pkg::ST_WAKE] = sie.bus_activity &
            usb_control_r[usbl_pkg::CT_SLEEP];
        // release of forced reset counts as a bus reset
        flag_set[usbl_pkg::ST_RST] = sie.bus_reset |
            (force_bus_reset_q_r & ~usb_control_r[usbl_pkg::CT_FORCE_BUS_RESET]);
        flag_set[usbl_pkg::ST_SOF] = sof_any;
    end

    // write of zero clears, set wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_status_r <= usbl_pkg::STATUS_RST;
        end else if (wr_status) begin
            irq_status_r <= (irq_status_r & reg_wdata) | flag_set;
        end else begin
            irq_status_r <= irq_status_r | flag_set;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_r <= usbl_pkg::MASK_RST;
        end else if (reg_wr && reg_addr == usbl_pkg::ADR_MASK) begin
            irq_mask_r <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            usb_control_r <= usbl_pkg::CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                usb_control_r <= reg_wdata[3:0];
            end
            if (sie.bus_activity) begin
                usb_control_r[usbl_pkg::CT_SLEEP] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            force_bus_reset_q_r <= 1'b0;
        end else begin
            force_bus_reset_q_r <= usb_control_r[usbl_pkg::CT_FORCE_BUS_RESET];
        end
    end

    // check off from forced sleep until resume ends or a bus or forced reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chk_en_r <= 1'b1;
        end else if (usb_rst || sie.resume_end) begin
            chk_en_r <= 1'b1;
        end else if (wr_ctrl && reg_wdata[usbl_pkg::CT_SLEEP]) begin
            chk_en_r <= 1'b0;
        end
    end

    // saturates one past the limit so the flag is raised once per idle spell
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_r <= 20'h00000;
        end else if (!chk_en_r || !sie.bus_idle) begin
            idle_cnt_r <= 20'h00000;
        end else if (idle_cnt_r <= IDLE_LIM) begin
            idle_cnt_r <= idle_cnt_r + 20'h00001;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            function_address_r <= usbl_pkg::FADDR_RST;
        end else if (usb_rst) begin
            function_address_r <= usbl_pkg::FADDR_RST;
        end else if (reg_wr && reg_addr == usbl_pkg::ADR_FADDR) begin
            function_address_r <= reg_wdata[6:0];
        end
    end

    // capture with fixed low pid pair only
    // frozen while transfer done is set
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            token_kind_r <= usbl_pkg::TOK_OUT;
            done_ep_r <= 2'h0;
        end else if (sie.token_valid && !irq_status_r[usbl_pkg::ST_DONE] &&
                     sie.token_pid[1:0] == usbl_pkg::PID_FIXED_LO) begin
            token_kind_r <= sie.token_pid[3:2];
            done_ep_r <= sie.token_ep;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            line_se0_r <= 1'b0;
            line_k_r <= 1'b0;
        end else begin
            line_se0_r <= sie.se0;
            line_k_r <= sie.kstate;
        end
    end

    // hardware updates follow the software write so they win a collision
    for (genvar i = 0; i < usbl_pkg::NUM_EP; i++) begin : g_ep
        logic sel;
        assign sel = sie.token_ep == 2'(i);
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                endpoint_tx_control_r[i] <= usbl_pkg::EP_RST;
            end else if (usb_rst) begin
                endpoint_tx_control_r[i] <= usbl_pkg::EP_RST;
            end else begin
                if (reg_wr && reg_addr == usbl_pkg::ADR_EP0 + 4'(i)) begin
                    endpoint_tx_control_r[i] <= reg_wdata;
                end
                // toggle on setup and host ack
                if (sel && sie.token_valid &&
                    sie.token_pid[3:2] == usbl_pkg::TOK_SETUP) begin
                    endpoint_tx_control_r[i][usbl_pkg::EP_TOGGLE] <= 1'b1;
                end else if (sel && sie.host_ack) begin
                    endpoint_tx_control_r[i][usbl_pkg::EP_TOGGLE] <=
                        ~endpoint_tx_control_r[i][usbl_pkg::EP_TOGGLE];
                end
                // nak after a done in or setup
                if (sel && done_set && (token_kind_r == usbl_pkg::TOK_IN ||
                    token_kind_r == usbl_pkg::TOK_SETUP)) begin
                    endpoint_tx_control_r[i][usbl_pkg::EP_ST_HI:
                        usbl_pkg::EP_ST_LO] <= usbl_pkg::TXS_NAK;
                end
            end
        end
    end

    // valid endpoints nak while done is pending
    always_comb begin
        ans.in_answer = usbl_pkg::TXS_OFF;
        if (ep_ok && !usb_rst) begin
            ans.in_answer = usbl_pkg::usbl_txs_t'(
                ep_cur[usbl_pkg::EP_ST_HI:usbl_pkg::EP_ST_LO]);
            if (ans.in_answer == usbl_pkg::TXS_VALID &&
                irq_status_r[usbl_pkg::ST_DONE]) begin
                ans.in_answer = usbl_pkg::TXS_NAK;
            end
        end
        ans.tx_toggle = ep_cur[usbl_pkg::EP_TOGGLE];
        // length trusted as written by software
        ans.tx_len = ep_cur[usbl_pkg::EP_LEN_HI:0];
        // nonzero out data stalled when status expected
        ans.out_stall = sie.out_end & ep_cur[usbl_pkg::EP_EXPECT] &
            (sie.out_len != 4'h0);
        ans.addr_match = sie.token_addr == function_address_r;
    end

    // wake event has its own request line
    assign irq = |(irq_status_r & irq_mask_r & ~(8'h01 << usbl_pkg::ST_WAKE))
        & ~cpu_irq_disable;
    assign wake_irq = irq_status_r[usbl_pkg::ST_WAKE] &
        irq_mask_r[usbl_pkg::ST_WAKE] & ~cpu_irq_disable;
    assign resume_drive = usb_control_r[usbl_pkg::CT_RESUME];
    assign regulator_off = usb_control_r[usbl_pkg::CT_REGOFF];
    assign suspended = usb_control_r[usbl_pkg::CT_SLEEP];
    assign iface_reset = usb_rst;

    always_comb begin
        rd_nxt = 8'h00;
        case (reg_addr)
            usbl_pkg::ADR_TOKEN: begin
                rd_nxt[usbl_pkg::TOK_HI:usbl_pkg::TOK_LO] = token_kind_r;
                rd_nxt[usbl_pkg::LINE_SE0] = line_se0_r;
                rd_nxt[usbl_pkg::LINE_K] = line_k_r;
            end
            usbl_pkg::ADR_STATUS: rd_nxt = irq_status_r;
            usbl_pkg::ADR_MASK: rd_nxt = irq_mask_r;
            usbl_pkg::ADR_CTRL: rd_nxt = {4'h0, usb_control_r};
            usbl_pkg::ADR_FADDR: rd_nxt = {1'b0, function_address_r};
            usbl_pkg::ADR_DONE_EP: rd_nxt = {6'h00, done_ep_r};
            default: begin
                if (reg_addr >= usbl_pkg::ADR_EP0 &&
                    32'(reg_addr - usbl_pkg::ADR_EP0) < usbl_pkg::NUM_EP) begin
                    rd_nxt = endpoint_tx_control_r[reg_addr[1:0] - 2'h1];
                end
            end
        endcase
    end

    // read data stand one cycle only, zero otherwise
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= 8'h00;
        end else begin
            reg_rdata_r <= reg_rd ? rd_nxt : 8'h00;
        end
    end
    assign reg_rdata = reg_rdata_r;

    sequence s_force_bus_reset_held;
        usb_control_r[usbl_pkg::CT_FORCE_BUS_RESET] [*2];
    endsequence
    sequence s_force_bus_reset_drop;
        !usb_control_r[usbl_pkg::CT_FORCE_BUS_RESET];
    endsequence

    property p_reset_clears;
        @(posedge clk_sys) disable iff (!rst_n)
        usb_rst |=> function_address_r == 7'h00 &&
            endpoint_tx_control_r[0] == 8'h00;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("address or endpoint kept over reset");

    property p_no_sw_set;
        @(posedge clk_sys) disable iff (!rst_n)
        (flag_set == 8'h00 && irq_status_r == 8'h00) |=>
            irq_status_r == 8'h00;
    endproperty
    a_no_sw_set: assert property (p_no_sw_set)
        else $error("status flag set without an event");

    property p_idle;
        @(posedge clk_sys) disable iff (!rst_n)
        (chk_en_r && sie.bus_idle && idle_cnt_r == IDLE_LIM) |=>
            irq_status_r[usbl_pkg::ST_IDLE];
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle sleep request missing");

    property p_lost;
        @(posedge clk_sys) disable iff (!rst_n)
        (err_any && irq_status_r[usbl_pkg::ST_ERR]) |=>
            irq_status_r[usbl_pkg::ST_LOST];
    endproperty
    a_lost: assert property (p_lost)
        else $error("event lost flag not raised");

    property p_wake;
        @(posedge clk_sys) disable iff (!rst_n)
        (sie.bus_activity && suspended) |=>
            irq_status_r[usbl_pkg::ST_WAKE] && !suspended;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake not flagged or sleep not ended");

    property p_force_bus_reset_release;
        @(posedge clk_sys) disable iff (!rst_n)
        s_force_bus_reset_held ##1 s_force_bus_reset_drop |=> irq_status_r[usbl_pkg::ST_RST];
    endproperty
    a_force_bus_reset_release: assert property (p_force_bus_reset_release)
        else $error("no bus reset flag after forced reset");

    property p_freeze;
        @(posedge clk_sys) disable iff (!rst_n)
        irq_status_r[usbl_pkg::ST_DONE] |=> $stable(token_kind_r);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("token kind changed while done pending");

    property p_done_nak;
        @(posedge clk_sys) disable iff (!rst_n)
        (sie.in_req && irq_status_r[usbl_pkg::ST_DONE]) |->
            ans.in_answer != usbl_pkg::TXS_VALID;
    endproperty
    a_done_nak: assert property (p_done_nak)
        else $error("data sent while done pending");

    property p_addr_top;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && reg_addr == usbl_pkg::ADR_FADDR) |=> !reg_rdata[7];
    endproperty
    a_addr_top: assert property (p_addr_top)
        else $error("address top bit read as one");

    property p_irq;
        @(posedge clk_sys) disable iff (!rst_n)
        (done_set && irq_mask_r[usbl_pkg::ST_DONE]) |=>
            (irq || cpu_irq_disable);
    endproperty
    a_irq: assert property (p_irq)
        else $error("masked-in event raised no interrupt");

endmodule : usbl_ctrl

// ---- src/usbl_pkg.sv ----
// usbl_pkg: constants, register map and carrier types of the usb link control
// assumes one 125 MHz system clock shared by the serial engine and registers
package usbl_pkg;

    // register indices on the 4-bit register port
    localparam logic [3:0] ADR_TOKEN = 4'h0;
    localparam logic [3:0] ADR_STATUS = 4'h1;
    localparam logic [3:0] ADR_MASK = 4'h2;
    localparam logic [3:0] ADR_CTRL = 4'h3;
    localparam logic [3:0] ADR_FADDR = 4'h4;
    localparam logic [3:0] ADR_EP0 = 4'h5;
    localparam logic [3:0] ADR_DONE_EP = 4'h8;
    localparam int NUM_EP = 3;

    // irq_status / irq_mask bit positions
    localparam int ST_IDLE = 7;
    localparam int ST_DMA = 6;
    localparam int ST_DONE = 5;
    localparam int ST_ERR = 4;
    localparam int ST_LOST = 3;
    localparam int ST_WAKE = 2;
    localparam int ST_RST = 1;
    localparam int ST_SOF = 0;

    // usb_control bit positions
    localparam int CT_RESUME = 3;
    localparam int CT_REGOFF = 2;
    localparam int CT_SLEEP = 1;
    localparam int CT_FORCE_BUS_RESET = 0;

    // token_line_status bit positions
    localparam int TOK_HI = 7;
    localparam int TOK_LO = 6;
    localparam int LINE_SE0 = 2;
    localparam int LINE_K = 1;

    // endpoint_tx_control bit positions
    localparam int EP_EXPECT = 7;
    localparam int EP_TOGGLE = 6;
    localparam int EP_ST_HI = 5;
    localparam int EP_ST_LO = 4;
    localparam int EP_LEN_HI = 3;

    // reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [3:0] CTRL_RST = 4'h6;
    localparam logic [6:0] FADDR_RST = 7'h00;
    localparam logic [7:0] EP_RST = 8'h00;

    // token pid codes (upper two bits) and the fixed lower pair
    localparam logic [1:0] PID_FIXED_LO = 2'h1;
    localparam logic [1:0] TOK_OUT = 2'h0;
    localparam logic [1:0] TOK_IN = 2'h2;
    localparam logic [1:0] TOK_SETUP = 2'h3;

    // idle time before a sleep request
    localparam int IDLE_TIME_MS = 3;
    localparam int CLK_KHZ = 125000;
    localparam int IDLE_CYC = IDLE_TIME_MS * CLK_KHZ;

    typedef enum logic [1:0] {
        TXS_OFF = 2'b00,
        TXS_STALL = 2'b01,
        TXS_NAK = 2'b10,
        TXS_VALID = 2'b11
    } usbl_txs_t;

    // events and levels from the serial engine
    typedef struct packed {
        logic token_valid;
        logic [3:0] token_pid;
        logic [1:0] token_ep;
        logic [6:0] token_addr;
        logic bus_idle;
        logic bus_activity;
        logic se0;
        logic kstate;
        logic bus_reset;
        logic keepalive;
        logic resume_end;
        logic dma_late;
        logic err_timeout;
        logic err_crc;
        logic err_stuff;
        logic err_frame;
        logic xfer_end;
        logic pid_ok;
        logic crc_ok;
        logic toggle_ok;
        logic overrun;
        logic hs_refused;
        logic host_ack;
        logic in_req;
        logic out_end;
        logic [3:0] out_len;
    } usbl_sie_t;

    // answers back to the serial engine
    typedef struct packed {
        usbl_txs_t in_answer;
        logic tx_toggle;
        logic [3:0] tx_len;
        logic out_stall;
        logic addr_match;
    } usbl_ans_t;

endpackage : usbl_pkg

// ---- verif/usbl_ctrl_test.sv ----
// usbl_ctrl_test: directed bench for the usb link control block
// assumes the host model drives the engine side; bench drives registers
`timescale 1ns/1ps
module usbl_ctrl_test;
    logic clk_sys;
    logic rst_n;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic cpu_irq_disable;
    logic irq;
    logic wake_irq;
    logic iface_reset;
    logic resume_drive;
    logic regulator_off;
    logic suspended;
    usbl_pkg::usbl_sie_t sie;
    usbl_pkg::usbl_ans_t ans;
    usbl_pkg::usbl_sie_t ev;
    usbl_pkg::usbl_ans_t seen;
    int error_cnt;
    int num_checks;

    // short idle count keeps the sleep test fast
    usbl_ctrl #(.IDLE_CYCLES(20)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cpu_irq_disable(cpu_irq_disable),
        .irq(irq), .wake_irq(wake_irq), .sie(sie), .ans(ans),
        .iface_reset(iface_reset), .resume_drive(resume_drive),
        .regulator_off(regulator_off), .suspended(suspended)
    );
    usbl_host_model u_host (.clk_sys(clk_sys), .sie(sie), .ans(ans));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rdc

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic t_reset;
        rdc(usbl_pkg::ADR_STATUS, 8'h00);
        rdc(usbl_pkg::ADR_MASK, 8'h00);
        rdc(usbl_pkg::ADR_CTRL, 8'h06);
        rdc(4'hF, 8'h00);
        chk({7'h0, regulator_off}, 8'h01);
        wr(usbl_pkg::ADR_STATUS, 8'hFF);
        rdc(usbl_pkg::ADR_STATUS, 8'h00);
        ev = '0;
        ev.bus_idle = 1'b1;
        u_host.hold(ev);
        repeat (25) @(posedge clk_sys);
        rdc(usbl_pkg::ADR_STATUS, 8'h80);
        ev = '0;
        u_host.hold(ev);
        wr(usbl_pkg::ADR_STATUS, 8'h7F);
        $display("test reset and idle done");
    endtask : t_reset

    task automatic t_wake;
        ev = '0;
        ev.bus_activity = 1'b1;
        u_host.send(ev, seen);
        rdc(usbl_pkg::ADR_STATUS, 8'h04);
        rdc(usbl_pkg::ADR_CTRL, 8'h04);
        chk({7'h0, suspended}, 8'h00);
        wr(usbl_pkg::ADR_MASK, 8'h04);
        chk({6'h0, wake_irq, irq}, 8'h02);
        wr(usbl_pkg::ADR_STATUS, 8'hFB);
        wr(usbl_pkg::ADR_CTRL, 8'h08);
        chk({6'h0, resume_drive, regulator_off}, 8'h02);
        wr(usbl_pkg::ADR_CTRL, 8'h00);
        $display("test wake done");
    endtask : t_wake

    task automatic t_events;
        wr(usbl_pkg::ADR_MASK, 8'h10);
        for (int i = 0; i < 4; i++) begin
            ev = '0;
            case (i)
                0: ev.err_timeout = 1'b1;
                1: ev.err_crc = 1'b1;
                2: ev.err_stuff = 1'b1;
                default: ev.err_frame = 1'b1;
            endcase
            u_host.send(ev, seen);
            rdc(usbl_pkg::ADR_STATUS, 8'h10);
            chk({7'h0, irq}, 8'h01);
            wr(usbl_pkg::ADR_STATUS, 8'hEF);
        end
        ev = '0;
        ev.keepalive = 1'b1;
        ev.err_crc = 1'b1;
        u_host.send(ev, seen);
        cpu_irq_disable <= 1'b1;
        u_host.send(ev, seen);
        rdc(usbl_pkg::ADR_STATUS, 8'h19);
        wr(usbl_pkg::ADR_MASK, 8'h01);
        chk({7'h0, irq}, 8'h00);
        wr(usbl_pkg::ADR_STATUS, 8'hE6);
        ev = '0;
        ev.resume_end = 1'b1;
        ev.dma_late = 1'b1;
        u_host.send(ev, seen);
        rdc(usbl_pkg::ADR_STATUS, 8'h41);
        wr(usbl_pkg::ADR_STATUS, 8'h00);
        cpu_irq_disable <= 1'b0;
        $display("test events done");
    endtask : t_events

    task automatic t_xfer;
        // length written in the same write that enables the endpoint
        wr(usbl_pkg::ADR_EP0 + 4'h1, 8'h34);
        wr(usbl_pkg::ADR_EP0 + 4'h2, 8'h30);
        ev = '0;
        ev.token_ep = 2'h1;
        u_host.hold(ev);
        ev.token_valid = 1'b1;
        ev.token_pid = {usbl_pkg::TOK_IN, usbl_pkg::PID_FIXED_LO};
        u_host.send(ev, seen);
        chk({6'h0, seen.in_answer}, 8'h03);
        chk({4'h0, seen.tx_len}, 8'h04);
        ev.token_valid = 1'b0;
        ev.host_ack = 1'b1;
        u_host.send(ev, seen);
        ev.host_ack = 1'b0;
        ev.xfer_end = 1'b1;
        ev.pid_ok = 1'b1;
        ev.crc_ok = 1'b1;
        ev.toggle_ok = 1'b1;
        ev.hs_refused = 1'b1;
        u_host.send(ev, seen);
        rdc(usbl_pkg::ADR_STATUS, 8'h00);
        ev.hs_refused = 1'b0;
        wr(usbl_pkg::ADR_MASK, 8'h20);
        u_host.send(ev, seen);
        rdc(usbl_pkg::ADR_STATUS, 8'h20);
        chk({7'h0, irq}, 8'h01);
        rdc(usbl_pkg::ADR_EP0 + 4'h1, 8'h64);
        ev = '0;
        ev.token_ep = 2'h2;
        u_host.hold(ev);
        ev.token_valid = 1'b1;
        ev.token_pid = {usbl_pkg::TOK_SETUP, usbl_pkg::PID_FIXED_LO};
        ev.in_req = 1'b1;
        u_host.send(ev, seen);
        chk({6'h0, seen.in_answer}, 8'h02);
        rdc(usbl_pkg::ADR_TOKEN, 8'h80);
        rdc(usbl_pkg::ADR_DONE_EP, 8'h01);
        wr(usbl_pkg::ADR_STATUS, 8'hDF);
        u_host.send(ev, seen);
        chk({7'h0, seen.tx_toggle}, 8'h01);
        rdc(usbl_pkg::ADR_TOKEN, 8'hC0);
        rdc(usbl_pkg::ADR_EP0 + 4'h2, 8'h70);
        ev = '0;
        ev.token_valid = 1'b1;
        ev.token_pid = {usbl_pkg::TOK_OUT, usbl_pkg::PID_FIXED_LO};
        ev.se0 = 1'b1;
        ev.kstate = 1'b1;
        u_host.hold(ev);
        rdc(usbl_pkg::ADR_TOKEN, 8'h06);
        ev = '0;
        u_host.hold(ev);
        wr(usbl_pkg::ADR_EP0, 8'h80);
        for (int n = 0; n < 2; n++) begin
            ev.out_end = 1'b1;
            ev.out_len = (n == 0) ? 4'h3 : 4'h0;
            u_host.send(ev, seen);
            chk({7'h0, seen.out_stall}, (n == 0) ? 8'h01 : 8'h00);
        end
        wr(usbl_pkg::ADR_EP0, 8'h10);
        ev = '0;
        u_host.send(ev, seen);
        chk({6'h0, seen.in_answer}, 8'h01);
        $display("test transfer done");
    endtask : t_xfer

    task automatic t_busreset;
        rdc(usbl_pkg::ADR_TOKEN, 8'h00);
        wr(usbl_pkg::ADR_FADDR, 8'hFF);
        rdc(usbl_pkg::ADR_FADDR, 8'h7F);
        ev = '0;
        ev.token_addr = 7'h7F;
        ev.bus_reset = 1'b1;
        u_host.hold(ev);
        chk({7'h0, ans.addr_match}, 8'h01);
        @(posedge clk_sys);
        #1;
        chk({6'h0, iface_reset, ans.addr_match}, 8'h02);
        ev.bus_reset = 1'b0;
        u_host.hold(ev);
        rdc(usbl_pkg::ADR_STATUS, 8'h02);
        rdc(usbl_pkg::ADR_FADDR, 8'h00);
        rdc(usbl_pkg::ADR_EP0 + 4'h1, 8'h00);
        wr(usbl_pkg::ADR_STATUS, 8'hFD);
        wr(usbl_pkg::ADR_CTRL, 8'h01);
        chk({7'h0, iface_reset}, 8'h01);
        wr(usbl_pkg::ADR_FADDR, 8'h12);
        rdc(usbl_pkg::ADR_FADDR, 8'h00);
        wr(usbl_pkg::ADR_STATUS, 8'hFD);
        wr(usbl_pkg::ADR_CTRL, 8'h00);
        rdc(usbl_pkg::ADR_STATUS, 8'h02);
        $display("test bus reset done");
    endtask : t_busreset

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        error_cnt = 0;
        num_checks = 0;
        rst_n = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cpu_irq_disable = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset;
        t_wake;
        t_events;
        t_xfer;
        t_busreset;
        report_and_stop;
    end

    // tests need well under a thousand cycles
    initial begin
        #50000;
        error_cnt++;
        report_and_stop;
    end
endmodule : usbl_ctrl_test

// ---- verif/usbl_host_model.sv ----
// usbl_host_model: serial engine events as the host traffic produces them
// assumes the bench calls its tasks; levels persist, events last one cycle
`timescale 1ns/1ps
module usbl_host_model (
    // clock
    input wire logic clk_sys,
    // engine events and the block's answers
    output usbl_pkg::usbl_sie_t sie,
    input wire usbl_pkg::usbl_ans_t ans
);
    // levels such as idle, line state and bus reset stay between events
    usbl_pkg::usbl_sie_t lvl;

    initial begin
        lvl = '0;
        sie = '0;
    end

    task automatic hold(input usbl_pkg::usbl_sie_t v);
        @(posedge clk_sys);
        lvl = v;
        sie <= v;
        #1;
    endtask : hold

    // answer sampled inside the event cycle, where it stands
    task automatic send(input usbl_pkg::usbl_sie_t v,
                        output usbl_pkg::usbl_ans_t seen);
        @(posedge clk_sys);
        sie <= v | lvl;
        #1 seen = ans;
        @(posedge clk_sys);
        sie <= lvl;
        #1;
    endtask : send
endmodule : usbl_host_model
